// File: logic/audio_ctrl_regs.sv
// Control and status register bank of the audio receiver and DAC.
// Assumes the control port deframer delivers whole words and requests.
`timescale 1ns/100ps
`default_nettype none
module audio_ctrl_regs (
  // Clock and reset.
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  // Word-level write from the control port deframer.
  input  wire logic       i_wr_stb,
  input  wire logic [6:0] i_wr_addr,
  input  wire logic [15:0] i_wr_data,
  // Word-level read request and answer.
  input  wire logic       i_rd_req,
  input  wire logic [6:0] i_rd_addr,
  output var  logic       o_rd_valid,
  output var  logic       o_rd_flag,
  output var  logic [6:0] o_rd_addr,
  output var  logic [15:0] o_rd_data,
  // Status levels from receiver, PLL and interpolator.
  input  wire logic       i_interp_muting,
  input  wire logic       i_pll_locked,
  input  wire logic       i_decoder_locked,
  input  wire logic       i_pcm_absent,
  input  wire logic [1:0] i_detected_rate,
  input  wire logic       i_preemph,
  input  wire logic [1:0] i_clock_accuracy,
  // Control outputs to the data path.
  output var  logic       o_dac_power_on,
  output var  logic       o_slicer_input_select,
  output var  logic       o_clock_source_select,
  output var  logic       o_clk_master,
  output var  logic       o_dac_source_select,
  output var  logic [1:0] o_serial_format,
  output var  logic [1:0] o_filter_mode,
  output var  logic [3:0] o_treble_gain_db,
  output var  logic [4:0] o_bass_gain_db,
  output var  logic [1:0] o_deemph_select,
  output var  logic       o_deemph_enable,
  output var  logic       o_soft_mute,
  output var  logic [5:0] o_volume_atten,
  output var  logic [5:0] o_volume_atten_db,
  output var  logic       o_volume_full_mute,
  output var  logic       o_mute_on_unlock,
  output var  logic       o_hard_mute,
  output var  logic       o_pll_reset
);
  import audio_ctrl_pkg::*;

  typedef struct packed {
    logic        power;
    logic        slicer;
    logic        clksrc;
    logic        dacsrc;
    logic [1:0]  format;
    logic [1:0]  fmode;
    logic [3:0]  bass;
    logic [1:0]  treble;
    logic [1:0]  deemph;
    logic        smute;
    logic [5:0]  volume;
    logic        automute;
    logic        pllrst;
    logic        master;
    logic [3:0]  treble_db;
    logic [4:0]  bass_db;
    logic        deemph_en;
    logic [5:0]  vol_db;
    logic        vol_mute;
    logic        hard_mute;
    logic        rd_valid;
    logic        rd_flag;
    logic [6:0]  rd_addr;
    logic [15:0] rd_data;
  } regs_state_type;

  regs_state_type state;
  regs_state_type next_state;
  logic [ST_WIDTH-1:0] status;

  // ==========================================================
  // Status levels cross in through two flops before any use.
  status_sync #(
    .WIDTH (ST_WIDTH)
  ) u_status_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_async ({i_clock_accuracy, i_preemph, i_detected_rate,
               i_pcm_absent, i_decoder_locked, i_pll_locked,
               i_interp_muting}),
    .o_sync  (status)
  );

  // ==========================================================
  // Register writes, derived controls and read answers.
  always_comb begin
    next_state          = state;
    next_state.rd_valid = 1'b0;
    if (i_wr_stb) begin
      unique case (i_wr_addr)
        ADDR_SYSTEM: begin
          next_state.power  = i_wr_data[POS_POWER];
          next_state.slicer = i_wr_data[POS_SLICER];
          next_state.clksrc = i_wr_data[POS_CLKSRC];
          next_state.dacsrc = i_wr_data[POS_DACSRC];
          next_state.format = i_wr_data[POS_FORMAT +: 2];
        end
        ADDR_SOUND: begin
          next_state.fmode  = i_wr_data[POS_FMODE +: 2];
          next_state.bass   = i_wr_data[POS_BASS +: 4];
          next_state.treble = i_wr_data[POS_TREBLE +: 2];
          next_state.deemph = i_wr_data[POS_DEEMPH +: 2];
          next_state.smute  = i_wr_data[POS_SMUTE];
        end
        ADDR_VOLUME: begin
          next_state.volume = i_wr_data[POS_VOLUME +: 6];
        end
        ADDR_MUX: begin
          // Reserved bits above auto mute are dropped here.
          next_state.automute = i_wr_data[POS_AUTOMUTE];
          next_state.pllrst   = i_wr_data[POS_PLLRST];
        end
        ADDR_RESTORE: begin
          // Only control fields return; status keeps running.
          next_state.power    = RST_POWER;
          next_state.slicer   = RST_SLICER;
          next_state.clksrc   = RST_CLKSRC;
          next_state.dacsrc   = RST_DACSRC;
          next_state.format   = RST_FORMAT;
          next_state.fmode    = RST_FMODE;
          next_state.bass     = RST_BASS;
          next_state.treble   = RST_TREBLE;
          next_state.deemph   = RST_DEEMPH;
          next_state.smute    = RST_SMUTE;
          next_state.volume   = RST_VOLUME;
          next_state.automute = RST_AUTOMUTE;
          next_state.pllrst   = RST_PLLRST;
        end
        default: begin
          // Unmapped write addresses are ignored.
        end
      endcase
    end

    // Receiver as clock source makes us master on both ports.
    next_state.master = !next_state.clksrc;

    // Undefined filter code 10 is treated as flat.
    if (next_state.fmode == FMODE_MIN ||
        next_state.fmode == FMODE_MAX) begin
      next_state.treble_db = {1'b0, next_state.treble, 1'b0};
      next_state.bass_db   = {next_state.bass, 1'b0};
      if (next_state.fmode == FMODE_MIN &&
          next_state.bass_db > BASS_MIN_SAT_DB) begin
        next_state.bass_db = BASS_MIN_SAT_DB;
      end
      if (next_state.fmode == FMODE_MAX &&
          next_state.bass_db > BASS_MAX_SAT_DB) begin
        next_state.bass_db = BASS_MAX_SAT_DB;
      end
    end else begin
      next_state.treble_db = 4'h0;
      next_state.bass_db   = 5'h00;
    end

    next_state.deemph_en = (next_state.deemph != 2'h0);

    // Codes 0 and 1 are both unity; the top codes mute fully.
    if (next_state.volume <= VOL_UNITY_CODE) begin
      next_state.vol_db   = 6'h00;
      next_state.vol_mute = 1'b0;
    end else if (next_state.volume <= VOL_LAST_CODE) begin
      next_state.vol_db   = next_state.volume - VOL_UNITY_CODE;
      next_state.vol_mute = 1'b0;
    end else begin
      next_state.vol_db   = VOL_FLOOR_DB;
      next_state.vol_mute = 1'b1;
    end

    // Loss of PLL lock hard-mutes only while auto mute is on.
    next_state.hard_mute = next_state.automute && !status[ST_PLL];

    // Answer: address echo with valid flag, then the data word.
    if (i_rd_req) begin
      next_state.rd_valid = 1'b1;
      next_state.rd_addr  = i_rd_addr;
      next_state.rd_data  = 16'h0000;
      next_state.rd_flag  = 1'b0;
      unique case (i_rd_addr)
        ADDR_INTERP: begin
          next_state.rd_data[POS_MUTESTAT] = status[ST_INTERP];
        end
        ADDR_RXSTATUS: begin
          next_state.rd_data[POS_PLLLOCK] = status[ST_PLL];
          next_state.rd_data[POS_DECLOCK] =
            status[ST_DEC] && !status[ST_PCM];
          next_state.rd_data[POS_RATE +: 2] =
            status[ST_RATE +: 2];
          next_state.rd_data[POS_PCM] = status[ST_PCM];
          next_state.rd_data[POS_PRE] = status[ST_PRE];
          next_state.rd_data[POS_ACC +: 2] =
            status[ST_ACC +: 2];
        end
        default: begin
          next_state.rd_flag = 1'b1;
        end
      endcase
    end
  end

  // Reset loads the same defaults that the restore write applies.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state          <= '0;
      state.power    <= RST_POWER;
      state.slicer   <= RST_SLICER;
      state.clksrc   <= RST_CLKSRC;
      state.dacsrc   <= RST_DACSRC;
      state.format   <= RST_FORMAT;
      state.fmode    <= RST_FMODE;
      state.bass     <= RST_BASS;
      state.treble   <= RST_TREBLE;
      state.deemph   <= RST_DEEMPH;
      state.smute    <= RST_SMUTE;
      state.volume   <= RST_VOLUME;
      state.automute <= RST_AUTOMUTE;
      state.pllrst   <= RST_PLLRST;
      state.master   <= !RST_CLKSRC;
      state.hard_mute <= RST_AUTOMUTE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs come straight from the state flops.
  assign o_dac_power_on        = state.power;
  assign o_slicer_input_select = state.slicer;
  assign o_clock_source_select = state.clksrc;
  assign o_clk_master          = state.master;
  assign o_dac_source_select   = state.dacsrc;
  assign o_serial_format       = state.format;
  assign o_filter_mode         = state.fmode;
  assign o_treble_gain_db      = state.treble_db;
  assign o_bass_gain_db        = state.bass_db;
  assign o_deemph_select       = state.deemph;
  assign o_deemph_enable       = state.deemph_en;
  assign o_soft_mute           = state.smute;
  assign o_volume_atten        = state.volume;
  assign o_volume_atten_db     = state.vol_db;
  assign o_volume_full_mute    = state.vol_mute;
  assign o_mute_on_unlock      = state.automute;
  assign o_hard_mute           = state.hard_mute;
  assign o_pll_reset           = state.pllrst;
  assign o_rd_valid            = state.rd_valid;
  assign o_rd_flag             = state.rd_flag;
  assign o_rd_addr             = state.rd_addr;
  assign o_rd_data             = state.rd_data;

  // ==========================================================
  // Checks on the register bank behaviour.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_restore_defaults: assert property (
    i_wr_stb && i_wr_addr == ADDR_RESTORE |=> o_soft_mute &&
    o_dac_power_on && o_volume_atten == 6'h00 && o_mute_on_unlock &&
    !o_pll_reset && o_dac_source_select)
    else $error("restore write did not bring back defaults");
  a_power_write: assert property (
    i_wr_stb && i_wr_addr == ADDR_SYSTEM |=>
    o_dac_power_on == $past(i_wr_data[POS_POWER]))
    else $error("power bit did not follow the write");
  a_clock_master: assert property (
    o_clk_master == !o_clock_source_select)
    else $error("clock master disagrees with clock source");
  a_bass_min_cap: assert property (
    o_filter_mode == FMODE_MIN |-> o_bass_gain_db <= BASS_MIN_SAT_DB)
    else $error("bass gain above minimum mode cap");
  a_bass_max_sat: assert property (
    i_wr_stb && i_wr_addr == ADDR_SOUND &&
    i_wr_data[POS_FMODE +: 2] == FMODE_MAX &&
    i_wr_data[POS_BASS +: 4] >= 4'hC |=>
    o_bass_gain_db == BASS_MAX_SAT_DB)
    else $error("bass gain not saturated in maximum mode");
  a_volume_mute: assert property (
    o_volume_atten > VOL_LAST_CODE |-> o_volume_full_mute &&
    o_volume_atten_db == VOL_FLOOR_DB)
    else $error("top volume codes do not mute");
  a_hard_mute_lock: assert property (
    !status[ST_PLL] ##1 !status[ST_PLL] |-> o_hard_mute ||
    !o_mute_on_unlock)
    else $error("lost lock without hard mute");
  a_read_rx_lock: assert property (
    i_rd_req && i_rd_addr == ADDR_RXSTATUS |=> o_rd_valid &&
    !o_rd_flag && o_rd_data[POS_DECLOCK] ==
    ($past(status[ST_DEC]) && !$past(status[ST_PCM])))
    else $error("receiver lock readback wrong");
  a_read_invalid: assert property (
    i_rd_req && i_rd_addr != ADDR_RXSTATUS &&
    i_rd_addr != ADDR_INTERP |=> o_rd_valid && o_rd_flag &&
    o_rd_data == 16'h0000)
    else $error("invalid read not flagged");
  a_mux_reserved: assert property (
    i_wr_stb && i_wr_addr == ADDR_MUX |=>
    o_mute_on_unlock == $past(i_wr_data[POS_AUTOMUTE]) &&
    o_pll_reset == $past(i_wr_data[POS_PLLRST]))
    else $error("multiplex write mishandled");

endmodule : audio_ctrl_regs
`default_nettype wire

// File: logic/audio_ctrl_pkg.sv
// Constants shared by the audio DAC control register bank.
// Assumes word-level register transfers arrive already deframed.
`default_nettype none
package audio_ctrl_pkg;

  // ==========================================================
  // Register addresses (7-bit register address space).
  localparam logic [6:0] ADDR_SYSTEM   = 7'h00;
  localparam logic [6:0] ADDR_SOUND    = 7'h10;
  localparam logic [6:0] ADDR_VOLUME   = 7'h11;
  localparam logic [6:0] ADDR_MUX      = 7'h40;
  localparam logic [6:0] ADDR_RESTORE  = 7'h7F;
  localparam logic [6:0] ADDR_INTERP   = 7'h18;
  localparam logic [6:0] ADDR_RXSTATUS = 7'h38;

  // ==========================================================
  // Field positions inside the 16-bit data word.
  localparam int POS_POWER     = 13;
  localparam int POS_SLICER    = 10;
  localparam int POS_CLKSRC    = 9;
  localparam int POS_DACSRC    = 6;
  localparam int POS_FORMAT    = 3;
  localparam int POS_FMODE     = 12;
  localparam int POS_BASS      = 8;
  localparam int POS_TREBLE    = 3;
  localparam int POS_DEEMPH    = 1;
  localparam int POS_SMUTE     = 0;
  localparam int POS_VOLUME    = 0;
  localparam int POS_AUTOMUTE  = 1;
  localparam int POS_PLLRST    = 0;
  localparam int POS_MUTESTAT  = 0;
  localparam int POS_PLLLOCK   = 10;
  localparam int POS_DECLOCK   = 8;
  localparam int POS_RATE      = 6;
  localparam int POS_PCM       = 5;
  localparam int POS_PRE       = 3;
  localparam int POS_ACC       = 0;

  // ==========================================================
  // Values after reset or restore.
  localparam logic       RST_POWER    = 1'b1;
  localparam logic       RST_SLICER   = 1'b0;
  localparam logic       RST_CLKSRC   = 1'b0;
  localparam logic       RST_DACSRC   = 1'b1;
  localparam logic [1:0] RST_FORMAT   = 2'h0;
  localparam logic [1:0] RST_FMODE    = 2'h0;
  localparam logic [3:0] RST_BASS     = 4'h0;
  localparam logic [1:0] RST_TREBLE   = 2'h0;
  localparam logic [1:0] RST_DEEMPH   = 2'h0;
  localparam logic       RST_SMUTE    = 1'b1;
  localparam logic [5:0] RST_VOLUME   = 6'h00;
  localparam logic       RST_AUTOMUTE = 1'b1;
  localparam logic       RST_PLLRST   = 1'b0;

  // ==========================================================
  // Filter modes, gain limits and volume code points.
  localparam logic [1:0] FMODE_FLAT = 2'h0;
  localparam logic [1:0] FMODE_MIN  = 2'h1;
  localparam logic [1:0] FMODE_MAX  = 2'h3;
  localparam logic [4:0] BASS_MIN_SAT_DB = 5'h12;
  localparam logic [4:0] BASS_MAX_SAT_DB = 5'h18;
  localparam logic [5:0] VOL_UNITY_CODE  = 6'h01;
  localparam logic [5:0] VOL_LAST_CODE   = 6'h3D;
  localparam logic [5:0] VOL_FLOOR_DB    = 6'h3C;

  // ==========================================================
  // Status vector layout and synchroniser depth.
  localparam int ST_INTERP = 0;
  localparam int ST_PLL    = 1;
  localparam int ST_DEC    = 2;
  localparam int ST_PCM    = 3;
  localparam int ST_RATE   = 4;
  localparam int ST_PRE    = 6;
  localparam int ST_ACC    = 7;
  localparam int ST_WIDTH  = 9;
  localparam int SYNC_STAGES = 2;

endpackage : audio_ctrl_pkg
`default_nettype wire

// File: logic/status_sync.sv
// Two-flop synchroniser bank for status levels from other clock areas.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
`timescale 1ns/100ps
`default_nettype none
module status_sync #(
  parameter int WIDTH = 9
) (
  // Clock and reset.
  input  wire logic             i_mclk,
  input  wire logic             i_rst_b,
  // Raw and synchronised levels.
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);
  import audio_ctrl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // ==========================================================
  // Per-bit stages: the first flop feeds only the second.
  always_comb begin
    next_state = state;
    for (int i = 0; i < WIDTH; i++) begin
      next_state.meta[i]   = i_async[i];
      next_state.stable[i] = state.meta[i];
    end
  end

  // Registers clear to zero so status reads as idle after reset.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.stable;

endmodule : status_sync
`default_nettype wire

// File: dv/mcu_port_model.sv
// Word-level model of the controller on the register bank's control port.
// Assumes the bank samples requests on the rising edge of i_mclk.
`timescale 1ns/100ps
`default_nettype none
module mcu_port_model (
  // Clock.
  input  wire logic        i_mclk,
  // Requests towards the bank.
  output var  logic        o_wr_stb,
  output var  logic [6:0]  o_wr_addr,
  output var  logic [15:0] o_wr_data,
  output var  logic        o_rd_req,
  output var  logic [6:0]  o_rd_addr,
  // Answer from the bank.
  input  wire logic        i_rd_valid,
  input  wire logic        i_rd_flag,
  input  wire logic [6:0]  i_rd_addr,
  input  wire logic [15:0] i_rd_data
);
  // ==========================================================
  // Idle levels at time zero.
  initial begin
    o_wr_stb  = 1'b0;
    o_wr_addr = 7'h00;
    o_wr_data = 16'h0000;
    o_rd_req  = 1'b0;
    o_rd_addr = 7'h00;
  end

  // ==========================================================
  // One word per strobe; lines are inverted after use so stale values
  // can never pass for a fresh request.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_wr_stb  <= 1'b1;
    o_wr_addr <= a;
    o_wr_data <= (a == 7'h40) ? (d & 16'hFFC3) : d;
    @(posedge i_mclk);
    o_wr_stb  <= 1'b0;
    o_wr_addr <= ~a;
    o_wr_data <= ~d;
  endtask : wr

  // Read request; the answer stands for one cycle after the taking edge.
  task automatic rd(input logic [6:0] a, output logic [24:0] ans);
    @(posedge i_mclk);
    o_rd_req  <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_mclk);
    o_rd_req  <= 1'b0;
    o_rd_addr <= ~a;
    #1;
    ans = {i_rd_valid, i_rd_flag, i_rd_addr, i_rd_data};
  endtask : rd
endmodule : mcu_port_model
`default_nettype wire

// File: dv/audio_dac_control_registers_tb.sv
// Self-checking bench for the audio DAC control register bank.
// Assumes mcu_port_model drives the word-level control port.
`timescale 1ns/100ps
`default_nettype none
module audio_dac_control_registers_tb;
  // ==========================================================
  // Signals and shadow of the writable fields.
  logic        i_mclk, i_rst_b, i_wr_stb, i_rd_req, o_rd_valid, o_rd_flag;
  logic [6:0]  i_wr_addr, i_rd_addr, o_rd_addr;
  logic [15:0] i_wr_data, o_rd_data;
  logic [8:0]  st;
  logic        o_dac_power_on, o_slicer_input_select, o_clock_source_select;
  logic        o_clk_master, o_dac_source_select, o_deemph_enable;
  logic        o_soft_mute, o_volume_full_mute, o_mute_on_unlock;
  logic        o_hard_mute, o_pll_reset;
  logic [1:0]  o_serial_format, o_filter_mode, o_deemph_select;
  logic [3:0]  o_treble_gain_db;
  logic [4:0]  o_bass_gain_db;
  logic [5:0]  o_volume_atten, o_volume_atten_db;
  logic [37:0] act;
  logic [15:0] gains;
  logic [24:0] ans, e;
  int          failures, n_tests;
  logic        pw, sl, cs, ds, mt, am, pr;
  logic [1:0]  fmt, fm, tr, de;
  logic [3:0]  bs;
  logic [5:0]  vol;
  // Writes in order, each beside its expected {treble dB, bass dB,
  // volume dB, full mute}; the first two rows are the start-up string.
  localparam logic [38:0] ROWS [23] = '{
    {7'h40, 16'h0003, 16'h0000}, {7'h7F, 16'h0000, 16'h0000},
    {7'h00, 16'hFFFF, 16'h0000}, {7'h00, 16'h0000, 16'h0000},
    {7'h00, 16'h0008, 16'h0000}, {7'h00, 16'h0010, 16'h0000},
    {7'h10, 16'h191F, 16'h6900}, {7'h10, 16'h1A0A, 16'h2900},
    {7'h10, 16'h3C14, 16'h4C00}, {7'h10, 16'h3B00, 16'h0B00},
    {7'h10, 16'h2F1F, 16'h0000}, {7'h10, 16'h0F1E, 16'h0000},
    {7'h11, 16'h0001, 16'h0000}, {7'h11, 16'h0002, 16'h0002},
    {7'h11, 16'h003D, 16'h0078}, {7'h11, 16'h003E, 16'h0079},
    {7'h11, 16'h003F, 16'h0079}, {7'h11, 16'hFFC5, 16'h0008},
    {7'h11, 16'h0000, 16'h0000}, {7'h40, 16'h0001, 16'h0000},
    {7'h40, 16'h0002, 16'h0000}, {7'h20, 16'hFFFF, 16'h0000},
    {7'h7F, 16'hFFFF, 16'h0000}};
  // Status patterns; the last leaves the clock PLL out of lock.
  localparam logic [8:0] PATS [5] = '{9'h000, 9'h1FF, 9'h0AA, 9'h0F6, 9'h155};
  localparam logic [6:0] BADS [5] = '{7'h00, 7'h11, 7'h40, 7'h7F, 7'h55};

  // Control outputs gathered for one comparison.
  assign act = {o_dac_power_on, o_slicer_input_select, o_clock_source_select,
                o_clk_master, o_dac_source_select, o_serial_format,
                o_filter_mode, o_treble_gain_db, o_bass_gain_db,
                o_deemph_select, o_deemph_enable, o_soft_mute,
                o_volume_atten, o_volume_atten_db, o_volume_full_mute,
                o_mute_on_unlock, o_hard_mute, o_pll_reset};
  // Decoded gain and volume outputs, held against the table's own column.
  assign gains = {o_treble_gain_db, o_bass_gain_db, o_volume_atten_db,
                  o_volume_full_mute};

  // ==========================================================
  // Instances.
  mcu_port_model mcu (
    .i_mclk, .o_wr_stb(i_wr_stb), .o_wr_addr(i_wr_addr),
    .o_wr_data(i_wr_data), .o_rd_req(i_rd_req), .o_rd_addr(i_rd_addr),
    .i_rd_valid(o_rd_valid), .i_rd_flag(o_rd_flag),
    .i_rd_addr(o_rd_addr), .i_rd_data(o_rd_data));
  audio_ctrl_regs dut (
    .i_mclk, .i_rst_b, .i_wr_stb, .i_wr_addr, .i_wr_data, .i_rd_req,
    .i_rd_addr, .o_rd_valid, .o_rd_flag, .o_rd_addr, .o_rd_data,
    .i_interp_muting(st[0]), .i_pll_locked(st[1]),
    .i_decoder_locked(st[2]), .i_pcm_absent(st[3]),
    .i_detected_rate(st[5:4]), .i_preemph(st[6]),
    .i_clock_accuracy(st[8:7]), .o_dac_power_on, .o_slicer_input_select,
    .o_clock_source_select, .o_clk_master, .o_dac_source_select,
    .o_serial_format, .o_filter_mode, .o_treble_gain_db, .o_bass_gain_db,
    .o_deemph_select, .o_deemph_enable, .o_soft_mute, .o_volume_atten,
    .o_volume_atten_db, .o_volume_full_mute, .o_mute_on_unlock,
    .o_hard_mute, .o_pll_reset);

  // ==========================================================
  // Reference model of the writable fields and their decoding.
  task automatic dflt();
    {pw, sl, cs, ds} = 4'b1001;
    {fmt, fm, bs, tr, de} = 12'h000;
    mt = 1'b1;
    vol = 6'h00;
    {am, pr} = 2'b10;
  endtask : dflt

  // Only the documented field bits are taken, so reserved bits are ignored.
  task automatic upd(input logic [6:0] a, input logic [15:0] d);
    case (a)
      7'h00: {pw, sl, cs, ds, fmt} = {d[13], d[10], d[9], d[6], d[4:3]};
      7'h10: {fm, bs, tr, de, mt} = {d[13:12], d[11:8], d[4:3], d[2:0]};
      7'h11: vol = d[5:0];
      7'h40: {am, pr} = d[1:0];
      7'h7F: dflt();
      default: ;
    endcase
  endtask : upd

  // Mode 10 has no function of its own and reads as flat.
  function automatic logic [37:0] exp_ctrl();
    logic [3:0] t;
    logic [4:0] b;
    logic [5:0] v;
    t = 4'h0;
    b = 5'h00;
    if (fm == 2'h1 || fm == 2'h3) begin
      t = {1'b0, tr, 1'b0};
      b = {bs, 1'b0};
      if (fm == 2'h1 && b > 5'h12) b = 5'h12;
      if (fm == 2'h3 && b > 5'h18) b = 5'h18;
    end
    v = (vol < 6'h02) ? 6'h00 : (vol > 6'h3D) ? 6'h3C : vol - 6'h01;
    return {pw, sl, cs, ~cs, ds, fmt, fm, t, b, de, de != 2'h0, mt, vol, v,
            vol > 6'h3D, am, am & ~st[1], pr};
  endfunction : exp_ctrl

  task automatic check(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: %s, got %h expected %h", $time, what,
               got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // Clock, watchdog and main sequence.
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // The sequence needs well under a thousand cycles; allow five thousand.
  initial begin
    #(5000 * 4);
    failures++;
    $display("Error at %0t ns: watchdog expired", $time);
    test_done();
  end

  initial begin
    failures = 0;
    n_tests = 0;
    i_rst_b = 1'b0;
    st = 9'h002;
    dflt();
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
    check(act, exp_ctrl(), "values after reset");
    $display("Test reset done");
    for (int i = 0; i < 23; i++) begin
      mcu.wr(ROWS[i][38:32], ROWS[i][31:16]);
      upd(ROWS[i][38:32], ROWS[i][31:16]);
      #1;
      check(act, exp_ctrl(), "control outputs");
      check(gains, ROWS[i][15:0], "gain decode");
    end
    $display("Test writes done");
    foreach (PATS[k]) begin
      @(posedge i_mclk);
      st <= PATS[k];
      repeat (4) @(posedge i_mclk);
      e = {2'b10, 7'h38, 5'h00, st[1], 1'b0, st[2] & ~st[3], st[5:4],
           st[3], 1'b0, st[6], 1'b0, st[8:7]};
      mcu.rd(7'h38, ans);
      check(ans, e, "receiver status");
      mcu.rd(7'h18, ans);
      check(ans, {2'b10, 7'h18, 15'h0000, st[0]}, "mute status");
      check(act, exp_ctrl(), "hard mute");
    end
    foreach (BADS[k]) begin
      mcu.rd(BADS[k], ans);
      check(ans, {2'b11, BADS[k], 16'h0000}, "invalid read");
    end
    $display("Test reads done");
    mcu.wr(7'h40, 16'h0000);
    upd(7'h40, 16'h0000);
    #1;
    check(act, exp_ctrl(), "auto mute off");
    mcu.wr(7'h11, 16'h0030);
    upd(7'h11, 16'h0030);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    dflt();
    @(posedge i_mclk);
    #1;
    check(act, exp_ctrl(), "reset in mid-run");
    repeat (5) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    st <= 9'h002;
    repeat (5) @(posedge i_mclk);
    #1;
    check(act, exp_ctrl(), "relock after reset");
    $display("Test mute and reset done");
    test_done();
  end
endmodule : audio_dac_control_registers_tb
`default_nettype wire
